// [core/bfc_array_mem.sv]
// Word array with a write/read port on the system clock and a
// read-only port on the burst clock; both reads are registered.
`default_nettype none

module bfc_array_mem
    import bfc_pkg::*;
#(
    parameter int AW = 19,
    parameter int DW = 16
) (
    bfc_mem_if.mem port
);
    // Storage cells
    logic [DW-1:0] cells [2**AW];

    // Array comes up erased
    initial
    begin
        for (int i = 0; i < 2**AW; i++)
            cells[i] = WORD_ERASED[DW-1:0];
    end

    // System side write and read
    always_ff @(posedge port.clk_a)
    begin
        if (port.a_we)
            cells[port.a_addr] <= port.a_wdata;
        port.a_rdata <= cells[port.a_addr];
    end

    // Burst side read
    always_ff @(posedge port.clk_b)
    begin
        port.b_rdata <= cells[port.b_addr];
    end
endmodule // bfc_array_mem

`default_nettype wire

// [core/bfc_flash_ctrl.sv]
// Command sequencer, read path and burst engine of a word flash.
// Host strobes are asynchronous and synchronised; the burst pins are
// synchronous to burst_clk.
`default_nettype none

module bfc_flash_ctrl
    import bfc_pkg::*;
#(
    parameter int MEM_AW = 19,
    parameter int PROG_NS = PROG_TIME_NS,
    parameter logic [15:0] MAKER_CODE = 16'h00a5, // Arbitrary value
    parameter logic [15:0] PART_CODE = 16'h0b1c // Arbitrary value
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic burst_clk,
    input wire logic hw_reset_n,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] dq_i,
    output logic [DATA_W-1:0] dq_o,
    output logic dq_oe,
    input wire logic load_burst_addr_n,
    input wire logic burst_advance_n,
    output logic burst_end_flag_n,
    output logic [DATA_W-1:0] burst_dq_o,
    output logic ready_busy_out,
    output logic burst_mode_o,
    input wire logic erase_suspend_i,
    input wire logic [SECTOR_NUM-1:0] suspended_sectors,
    input wire logic [SECTOR_NUM-1:0] protected_sectors
);
    // Program time in cycles, rounded up
    localparam int PROG_CYC = (PROG_NS * CLK_MHZ + 999) / 1000;
    localparam int PCNT_W = $clog2(PROG_CYC + 1);

    // Refuse sizes the logic cannot serve; the algorithm needs 3 cycles
    if (MEM_AW > ADDR_W || MEM_AW < 8 || PROG_CYC < 3)
    begin : g_bad_param
        $error("bfc_flash_ctrl: parameter out of range");
    end

    // Memory link
    bfc_mem_if #(.AW(MEM_AW), .DW(DATA_W)) mem_bus (
        .clk_a(sys_clk),
        .clk_b(burst_clk)
    );

    bfc_array_mem #(.AW(MEM_AW), .DW(DATA_W)) u_mem (
        .port(mem_bus.mem)
    );

    // Pin synchronisers, two stages each
    logic [2:0] ctl_s1_q, ctl_s2_q; // {ce_n, oe_n, we_n}
    logic hwr_s1_q, hwr_s2_q;
    logic [ADDR_W-1:0] addr_s1_q, addr_s2_q;
    logic [DATA_W-1:0] dq_s1_q, dq_s2_q;

    always_ff @(posedge sys_clk)
    begin
        ctl_s1_q <= {ce_n, oe_n, we_n};
        ctl_s2_q <= ctl_s1_q;
        hwr_s1_q <= hw_reset_n;
        hwr_s2_q <= hwr_s1_q;
        addr_s1_q <= addr;
        addr_s2_q <= addr_s1_q;
        dq_s1_q <= dq_i;
        dq_s2_q <= dq_s1_q;
    end

    // Decoded bus cycles; any other strobe mix inhibits writing
    logic wr_act, rd_act, hw_rst;
    assign wr_act = !ctl_s2_q[2] && ctl_s2_q[1] && !ctl_s2_q[0];
    assign rd_act = !ctl_s2_q[2] && !ctl_s2_q[1] && ctl_s2_q[0];
    assign hw_rst = srst || !hwr_s2_q;

    // Write cycle capture
    logic wr_act_q, rd_act_q;
    logic [ADDR_W-1:0] cmd_addr_q; // Address taken at write start
    logic [DATA_W-1:0] cmd_data_q; // Data followed during write
    logic cmd_stb; // One cycle at write end

    always_ff @(posedge sys_clk)
    begin
        wr_act_q <= srst ? 1'b0 : wr_act;
        rd_act_q <= srst ? 1'b0 : rd_act;
        // Later falling strobe opens the cycle
        if (wr_act && !wr_act_q)
            cmd_addr_q <= addr_s2_q;
        // Data tracked until the first rising strobe
        if (wr_act)
            cmd_data_q <= dq_s2_q;
    end

    assign cmd_stb = wr_act_q && !wr_act;

    // Command field views
    logic [7:0] cmd;
    logic [CMD_ADDR_W-1:0] cadr;
    logic is_ul1, is_ul2;
    assign cmd = cmd_data_q[7:0];
    assign cadr = cmd_addr_q[CMD_ADDR_W-1:0];
    assign is_ul1 = cadr == UNLOCK1_ADDR && cmd == UNLOCK1_DATA;
    assign is_ul2 = cadr == UNLOCK2_ADDR && cmd == UNLOCK2_DATA;

    // Sequencer state
    bfc_state_t state_q;
    logic ul_cnt_q; // Unlock pair flag; cleared on reset and in array read, never set
    logic burst_q; // Burst mode flag
    logic bypass_ret_q; // Program returns to bypass mode
    logic [ADDR_W-1:0] pgm_addr_q;
    logic [DATA_W-1:0] pgm_data_q;
    logic [PCNT_W-1:0] pgm_cnt_q;
    logic timeout_q; // Timeout error status
    logic pgm_wr_q; // Array write pulse

    // Old word seen by the program algorithm, valid two cycles in
    logic [DATA_W-1:0] old_word;
    logic pgm_bad;
    assign old_word = mem_bus.a_rdata;
    assign pgm_bad = |(pgm_data_q & ~old_word);

    // Takes a program address/data cycle
    function automatic logic prog_ok(input logic [ADDR_W-1:0] a,
                                     input logic [SECTOR_NUM-1:0] prot);
        return !prot[bfc_sector(a)];
    endfunction

    // Command state machine; hardware reset returns to array read
    always_ff @(posedge sys_clk)
    begin
        pgm_wr_q <= 1'b0;
        if (hw_rst)
        begin
            state_q <= BFC_READ;
            ul_cnt_q <= 1'b0;
            bypass_ret_q <= 1'b0;
            pgm_cnt_q <= '0;
            timeout_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                // Idle array read; reset here simply stays
                BFC_READ:
                begin
                    ul_cnt_q <= 1'b0;
                    if (cmd_stb && is_ul1)
                        state_q <= BFC_UL1;
                end
                // First unlock seen
                BFC_UL1:
                begin
                    if (cmd_stb)
                        state_q <= is_ul2 ? BFC_UL2 : BFC_READ;
                end
                // Both unlocks seen; command decides
                BFC_UL2:
                begin
                    if (cmd_stb)
                    begin
                        if (cadr != UNLOCK1_ADDR)
                            state_q <= BFC_READ;
                        else if (cmd == CMD_PROGRAM)
                            state_q <= BFC_PGM_SETUP;
                        else if (cmd == CMD_AUTOSEL)
                            state_q <= BFC_AUTOSEL;
                        else if (cmd == CMD_BYPASS)
                            state_q <= BFC_BYPASS;
                        else if (cmd == CMD_BURST && !erase_suspend_i)
                            state_q <= BFC_BURST_CMD;
                        else
                            state_q <= BFC_READ;
                    end
                end
                // Fourth cycle carries enable or disable
                BFC_BURST_CMD:
                begin
                    if (cmd_stb)
                        state_q <= BFC_READ;
                end
                // Waiting for program address and data
                BFC_PGM_SETUP, BFC_BYP_PGM:
                begin
                    if (cmd_stb)
                    begin
                        bypass_ret_q <= state_q == BFC_BYP_PGM;
                        pgm_addr_q <= cmd_addr_q;
                        pgm_data_q <= cmd_data_q;
                        pgm_cnt_q <= '0;
                        // Reset aborts a non-bypass program before programming starts
                        if (state_q == BFC_PGM_SETUP && cmd == CMD_RESET)
                            state_q <= BFC_READ;
                        else if (prog_ok(cmd_addr_q, protected_sectors))
                            state_q <= BFC_PROG;
                        else
                            state_q <= state_q == BFC_BYP_PGM ?
                                       BFC_BYPASS : BFC_READ;
                    end
                end
                // Identification stays until reset
                BFC_AUTOSEL:
                begin
                    if (cmd_stb && cmd == CMD_RESET)
                        state_q <= BFC_READ;
                end
                // Only bypass program or bypass exit count
                BFC_BYPASS:
                begin
                    if (cmd_stb && cmd == CMD_PROGRAM)
                        state_q <= BFC_BYP_PGM;
                    else if (cmd_stb && cmd == CMD_BYP_RST1)
                        state_q <= BFC_BYP_RST;
                end
                // Exit needs the second cycle
                BFC_BYP_RST:
                begin
                    if (cmd_stb)
                        state_q <= cmd == CMD_BYP_RST2 ?
                                   BFC_READ : BFC_BYPASS;
                end
                // Internal algorithm; command writes fall on the floor
                BFC_PROG:
                begin
                    pgm_cnt_q <= pgm_cnt_q + 1'b1;
                    if (pgm_cnt_q == PCNT_W'(2) && pgm_bad)
                    begin
                        timeout_q <= 1'b1;
                        state_q <= BFC_ERROR;
                    end
                    else if (pgm_cnt_q == PCNT_W'(2))
                        pgm_wr_q <= 1'b1;
                    else if (pgm_cnt_q >= PCNT_W'(PROG_CYC))
                        state_q <= bypass_ret_q ?
                                   BFC_BYPASS : BFC_READ;
                end
                // Halted on timeout; reset command recovers
                BFC_ERROR:
                begin
                    if (cmd_stb && cmd == CMD_RESET)
                    begin
                        timeout_q <= 1'b0;
                        state_q <= BFC_READ;
                    end
                end
                default:
                    state_q <= BFC_READ;
            endcase
        end
    end

    // Burst mode flag; the reset command never touches it
    always_ff @(posedge sys_clk)
    begin
        if (hw_rst)
            burst_q <= 1'b0;
        else if (state_q == BFC_BURST_CMD && cmd_stb)
        begin
            if (cmd == BURST_ENABLE)
                burst_q <= 1'b1;
            else if (cmd == BURST_DISABLE)
                burst_q <= 1'b0;
        end
    end

    // Port a addressing; algorithm owns it while busy
    always_comb
    begin
        mem_bus.a_we = pgm_wr_q;
        mem_bus.a_wdata = pgm_data_q & old_word;
        if (state_q == BFC_PROG)
            mem_bus.a_addr = pgm_addr_q[MEM_AW-1:0];
        else
            mem_bus.a_addr = addr_s2_q[MEM_AW-1:0];
    end

    // Toggle bit flips on each new read while programming or halted on timeout
    logic toggle_q;
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            toggle_q <= 1'b0;
        else if (rd_act && !rd_act_q &&
                 (state_q == BFC_PROG || state_q == BFC_ERROR))
            toggle_q <= !toggle_q;
    end

    // Status word during program or after timeout
    logic [DATA_W-1:0] status_word;
    always_comb
    begin
        status_word = '0;
        status_word[POLL_BIT] = !pgm_data_q[POLL_BIT];
        status_word[TOGGLE_BIT] = toggle_q;
        status_word[TIMEOUT_BIT] = timeout_q;
    end

    // Identification answer
    logic [DATA_W-1:0] ident_word;
    always_comb
    begin
        case (addr_s2_q[7:0])
            AS_MAKER: ident_word = MAKER_CODE;
            AS_PART: ident_word = PART_CODE;
            AS_PROTECT: ident_word =
                protected_sectors[bfc_sector(addr_s2_q)] ?
                WORD_TRUE : WORD_FALSE;
            AS_BURST: ident_word = burst_q ? WORD_TRUE : WORD_FALSE;
            default: ident_word = WORD_FALSE;
        endcase
    end

    // Read data path; array word arrives one cycle after its address
    logic susp_hit;
    assign susp_hit = erase_suspend_i &&
                      suspended_sectors[bfc_sector(addr_s2_q)];

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            dq_o <= '0;
            dq_oe <= 1'b0;
        end
        else
        begin
            dq_oe <= rd_act;
            if (state_q == BFC_PROG || state_q == BFC_ERROR)
                dq_o <= status_word;
            else if (state_q == BFC_AUTOSEL)
                dq_o <= ident_word;
            else if (susp_hit)
                dq_o <= WORD_SUSP_STATUS;
            else
                dq_o <= mem_bus.a_rdata;
        end
    end

    // Ready output low while the algorithm runs
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            ready_busy_out <= 1'b1;
            burst_mode_o <= 1'b0;
        end
        else
        begin
            ready_busy_out <= state_q != BFC_PROG;
            burst_mode_o <= burst_q;
        end
    end

    // Burst domain: mode and reset cross as levels
    logic bm_s1_q, bm_s2_q;
    logic lrst_s1_q, lrst_s2_q;
    always_ff @(posedge burst_clk)
    begin
        bm_s1_q <= burst_q;
        bm_s2_q <= bm_s1_q;
        lrst_s1_q <= srst;
        lrst_s2_q <= lrst_s1_q;
    end

    // Burst address and word count, linear wrap within 32 words
    logic [ADDR_W-1:0] baddr_q, baddr_d;
    logic [BURST_IDX_W-1:0] bcnt_q, bcnt_d;
    // Next address feeds the array, so an advance edge shows the new word
    always_comb
    begin
        baddr_d = baddr_q;
        bcnt_d = bcnt_q;
        if (lrst_s2_q || !bm_s2_q)
        begin
            baddr_d = '0;
            bcnt_d = '0;
        end
        else if (!load_burst_addr_n)
        begin
            baddr_d = addr;
            bcnt_d = '0;
        end
        else if (!burst_advance_n)
        begin
            baddr_d[BURST_IDX_W-1:0] =
                baddr_q[BURST_IDX_W-1:0] + 1'b1;
            bcnt_d = bcnt_q + 1'b1;
        end
    end

    always_ff @(posedge burst_clk)
    begin
        baddr_q <= baddr_d;
        bcnt_q <= bcnt_d;
    end

    assign mem_bus.b_addr = baddr_d[MEM_AW-1:0];

    // End flag aligned with the registered array word
    always_ff @(posedge burst_clk)
    begin
        if (lrst_s2_q || !bm_s2_q)
            burst_end_flag_n <= 1'b1;
        else
            burst_end_flag_n <=
                bcnt_d != BURST_IDX_W'(BURST_LEN - 1);
    end

    assign burst_dq_o = mem_bus.b_rdata;
endmodule // bfc_flash_ctrl

`default_nettype wire

// [pkg/bfc_mem_if.sv]
// Two-port link between the command core and its array memory.
// Port a runs on the system clock, port b on the burst clock.
`default_nettype none

interface bfc_mem_if #(
    parameter int AW = 19,
    parameter int DW = 16
) (
    input wire logic clk_a,
    input wire logic clk_b
);
    logic a_we; // Write strobe, port a
    logic [AW-1:0] a_addr; // Read or write address, port a
    logic [DW-1:0] a_wdata; // Write data
    logic [DW-1:0] a_rdata; // Registered read data, port a
    logic [AW-1:0] b_addr; // Burst read address
    logic [DW-1:0] b_rdata; // Registered burst read data

    modport ctrl (
        input clk_a, clk_b, a_rdata, b_rdata,
        output a_we, a_addr, a_wdata, b_addr
    );
    modport mem (
        input clk_a, clk_b, a_we, a_addr, a_wdata, b_addr,
        output a_rdata, b_rdata
    );
endinterface

`default_nettype wire

// [pkg/bfc_pkg.sv]
// Shared constants and types for the burst flash command controller.
// Assumes a word-wide array and a 50 MHz system clock.
`default_nettype none

package bfc_pkg;

    // Bus widths
    localparam int DATA_W = 16;
    localparam int ADDR_W = 19;
    localparam int CMD_ADDR_W = 11;
    localparam int SECTOR_NUM = 9;

    // Unlock cycle addresses and data
    localparam logic [10:0] UNLOCK1_ADDR = 11'h555;
    localparam logic [10:0] UNLOCK2_ADDR = 11'h2aa;
    localparam logic [7:0] UNLOCK1_DATA = 8'haa;
    localparam logic [7:0] UNLOCK2_DATA = 8'h55;

    // Command codes
    localparam logic [7:0] CMD_RESET = 8'hf0;
    localparam logic [7:0] CMD_AUTOSEL = 8'h90;
    localparam logic [7:0] CMD_PROGRAM = 8'ha0;
    localparam logic [7:0] CMD_BYPASS = 8'h20;
    localparam logic [7:0] CMD_BYP_RST1 = 8'h90;
    localparam logic [7:0] CMD_BYP_RST2 = 8'h00;
    localparam logic [7:0] CMD_BURST = 8'hc0;
    localparam logic [7:0] BURST_ENABLE = 8'h01;
    localparam logic [7:0] BURST_DISABLE = 8'h00;

    // Identification query offsets
    localparam logic [7:0] AS_MAKER = 8'h00;
    localparam logic [7:0] AS_PART = 8'h01;
    localparam logic [7:0] AS_PROTECT = 8'h02;
    localparam logic [7:0] AS_BURST = 8'h03;

    // Fixed answer words
    localparam logic [15:0] WORD_ERASED = 16'hffff;
    localparam logic [15:0] WORD_TRUE = 16'h0001;
    localparam logic [15:0] WORD_FALSE = 16'h0000;
    localparam logic [15:0] WORD_SUSP_STATUS = 16'h0080;

    // Status bit positions
    localparam int POLL_BIT = 7;
    localparam int TOGGLE_BIT = 6;
    localparam int TIMEOUT_BIT = 5;

    // Timing
    localparam int CLK_MHZ = 50;
    localparam int PROG_TIME_NS = 7000;
    localparam int BURST_LEN = 32;
    localparam int BURST_IDX_W = 5;

    // Command state machine
    typedef enum logic [3:0] {
        BFC_READ,
        BFC_UL1,
        BFC_UL2,
        BFC_PGM_SETUP,
        BFC_AUTOSEL,
        BFC_BURST_CMD,
        BFC_BYPASS,
        BFC_BYP_PGM,
        BFC_BYP_RST,
        BFC_PROG,
        BFC_ERROR
    } bfc_state_t;

    // Sector index of a word address
    function automatic logic [3:0] bfc_sector(input logic [18:0] a);
        if (a[18:17] == 2'b11) return 4'd8;
        if (a[18:17] == 2'b10) return 4'd7;
        if (a[18:16] != 3'b000) return {1'b0, a[18:16]} + 4'd3;
        if (a[15:14] != 2'b00) return 4'd3;
        if (a[13:12] == 2'b11) return 4'd2;
        if (a[13:12] == 2'b10) return 4'd1;
        return 4'd0;
    endfunction

endpackage

`default_nettype wire

// [verification/bfc_flash_checker.sv]
// Port-level assertions for the flash command controller.
// Bound into every controller; sees only its top ports.
`default_nettype none

module bfc_flash_checker (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic burst_clk,
    input wire logic hw_reset_n,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic dq_oe,
    input wire logic load_burst_addr_n,
    input wire logic burst_end_flag_n,
    input wire logic ready_busy_out,
    input wire logic burst_mode_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // Out of reset: idle bus, ready, non-burst
    a_reset_state: assert property (@(posedge sys_clk)
        disable iff (srst) $fell(srst) |-> !dq_oe && ready_busy_out
        && !burst_mode_o) else $error("bad state after reset");
    // Sync lag is 3 cycles, so 4 idle cycles must free the bus
    a_oe_quiet: assert property (@(posedge sys_clk)
        disable iff (srst) oe_n [*4] |-> !dq_oe)
        else $error("bus driven without output enable");
    a_we_quiet: assert property (@(posedge sys_clk)
        disable iff (srst) (!we_n) [*4] |-> !dq_oe)
        else $error("bus driven during write");
    a_ce_quiet: assert property (@(posedge sys_clk)
        disable iff (srst) ce_n [*4] |-> !dq_oe)
        else $error("bus driven while deselected");
    // Pin reset ends programming and burst mode
    a_hw_exit: assert property (@(posedge sys_clk)
        disable iff (srst) (!hw_reset_n) [*5] |-> ready_busy_out
        && !burst_mode_o) else $error("pin reset not obeyed");
    a_busy_hold: assert property (@(posedge sys_clk)
        disable iff (srst) $fell(ready_busy_out) |->
        (!ready_busy_out) [*3]) else $error("busy pulse too short");
    a_busy_locked: assert property (@(posedge sys_clk)
        disable iff (srst) !ready_busy_out && !burst_mode_o |=>
        !burst_mode_o) else $error("command taken while busy");
    // A fresh load restarts the word count
    a_load_flag: assert property (@(posedge burst_clk)
        disable iff (srst) !load_burst_addr_n |=> burst_end_flag_n)
        else $error("end flag low after load");
    a_idle_flag: assert property (@(posedge burst_clk)
        disable iff (srst) (!burst_mode_o) [*4] |-> burst_end_flag_n)
        else $error("end flag low outside burst mode");

    // Main scenarios reached
    c_prog: cover property (@(posedge sys_clk) $fell(ready_busy_out));
    c_burst: cover property (@(posedge sys_clk) $rose(burst_mode_o));
    c_end: cover property (@(posedge burst_clk) $fell(burst_end_flag_n));
endmodule // bfc_flash_checker

bind bfc_flash_ctrl bfc_flash_checker bfc_flash_checker_i (.sys_clk,
    .srst, .burst_clk, .hw_reset_n, .ce_n, .oe_n, .we_n, .dq_oe,
    .load_burst_addr_n, .burst_end_flag_n, .ready_busy_out,
    .burst_mode_o);

`default_nettype wire

// [verification/bfc_host_clk.sv]
// Host-side burst clock, 30 ns period, free phase to sys_clk.
// Runs only while the host asks; parked low between frames.
`default_nettype none

module bfc_host_clk (
    input wire logic run,
    output logic burst_clk
);
    timeunit 1ns;
    timeprecision 1ns;

    // Odd start offset keeps edges clear of the system clock
    initial
    begin
        burst_clk = 1'b0;
        #3;
        forever
        begin
            #15;
            burst_clk = run ? ~burst_clk : 1'b0;
        end
    end
endmodule // bfc_host_clk

`default_nettype wire

// [verification/testbench.sv]
// Self-checking bench for the flash command controller.
// Host cycles come from tasks; burst clock from the host model.
`default_nettype none

module testbench
    import bfc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic hw_reset_n = 1'b1;
    logic ce_n = 1'b1;
    logic oe_n = 1'b1;
    logic we_n = 1'b1;
    logic [ADDR_W-1:0] addr = 19'h00000;
    logic [DATA_W-1:0] dq_i = 16'h0000;
    logic load_burst_addr_n = 1'b1;
    logic burst_advance_n = 1'b1;
    logic erase_suspend_i = 1'b0;
    logic [SECTOR_NUM-1:0] suspended_sectors = 9'h002; // Sector one
    logic [SECTOR_NUM-1:0] protected_sectors = 9'h010; // Sector four
    logic run_bclk = 1'b1; // Clock runs through reset
    logic burst_clk;
    logic burst_end_flag_n;
    logic dq_oe;
    logic ready_busy_out;
    logic burst_mode_o;
    logic [DATA_W-1:0] dq_o;
    logic [DATA_W-1:0] burst_dq_o;
    int fail_count = 0;
    int checked = 0;
    int n;

    bfc_host_clk bfc_host_clk_i (.run(run_bclk), .burst_clk);
    // Short program time keeps the run brief
    bfc_flash_ctrl #(.PROG_NS(200)) bfc_flash_ctrl_i (.sys_clk, .srst,
        .burst_clk, .hw_reset_n, .ce_n, .oe_n, .we_n, .addr, .dq_i,
        .dq_o, .dq_oe, .load_burst_addr_n, .burst_advance_n,
        .burst_end_flag_n, .burst_dq_o, .ready_busy_out, .burst_mode_o,
        .erase_suspend_i, .suspended_sectors, .protected_sectors);

    // 50 MHz system clock
    initial
        forever #10 sys_clk = ~sys_clk;

    task automatic report_and_stop;
        if (fail_count == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e, g);
        checked++;
        if (g !== e)
        begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask

    // One write cycle; each strobe phase spans five clocks
    task automatic wr(input logic [18:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        addr <= a;
        dq_i <= d;
        ce_n <= 1'b0;
        we_n <= 1'b0;
        repeat (5) @(posedge sys_clk);
        ce_n <= 1'b1;
        we_n <= 1'b1;
        repeat (5) @(posedge sys_clk);
    endtask

    // Two unlock cycles, then the command byte
    task automatic cmd(input logic [7:0] c);
        wr(19'(UNLOCK1_ADDR), 16'(UNLOCK1_DATA));
        wr(19'(UNLOCK2_ADDR), 16'(UNLOCK2_DATA));
        wr(19'(UNLOCK1_ADDR), 16'(c));
    endtask

    // Read cycle, data checked once settled
    task automatic rd(input logic [18:0] a, input logic [15:0] e);
        @(posedge sys_clk);
        addr <= a;
        ce_n <= 1'b0;
        oe_n <= 1'b0;
        repeat (7) @(posedge sys_clk);
        #1;
        chk("dq_oe", 16'h0001, 16'(dq_oe));
        chk("dq_o", e, dq_o);
        ce_n <= 1'b1;
        oe_n <= 1'b1;
        repeat (5) @(posedge sys_clk);
    endtask

    // Busy must show, then clear within a bound
    task automatic wait_ready;
        chk("busy", 16'h0000, 16'(ready_busy_out));
        n = 0;
        while (ready_busy_out !== 1'b1 && n < 400)
        begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 400)
        begin
            fail_count++;
            report_and_stop();
        end
    endtask

    task automatic set_burst(input logic [7:0] v);
        cmd(CMD_BURST);
        wr(19'h00000, 16'(v));
    endtask

    initial
    begin
        repeat (3) @(posedge sys_clk);
        srst <= 1'b0;
        repeat (4) @(posedge burst_clk);
        run_bclk <= 1'b0;
        chk("mode", 16'h0000, 16'(burst_mode_o));
        rd(19'h00100, WORD_ERASED);
        cmd(CMD_AUTOSEL);
        rd(19'h00000, 16'h00a5);
        rd(19'h00001, 16'h0b1c);
        rd(19'h00002, WORD_FALSE);
        rd(19'h10002, WORD_TRUE);
        rd(19'h00003, WORD_FALSE);
        wr(19'h7ffff, 16'(CMD_RESET));
        rd(19'h00003, WORD_ERASED);
        cmd(CMD_PROGRAM);
        wr(19'h00100, 16'h1234);
        wait_ready();
        rd(19'h00100, 16'h1234);
        cmd(CMD_PROGRAM);
        wr(19'h00100, 16'hffff);
        repeat (30) @(posedge sys_clk);
        rd(19'h00100, 16'h0060);
        rd(19'h00100, 16'h0020);
        wr(19'h00000, 16'(CMD_RESET));
        rd(19'h00100, 16'h1234);
        cmd(CMD_PROGRAM);
        wr(19'h00000, 16'(CMD_RESET));
        wr(19'h00200, 16'h0000);
        rd(19'h00200, WORD_ERASED);
        cmd(CMD_BYPASS);
        wr(19'h00000, 16'(CMD_RESET));
        wr(19'h00000, 16'(CMD_PROGRAM));
        wr(19'h00300, 16'habcd);
        wait_ready();
        wr(19'h00123, 16'(CMD_BYP_RST1));
        wr(19'h00456, 16'(CMD_BYP_RST2));
        rd(19'h00300, 16'habcd);
        set_burst(BURST_ENABLE);
        chk("mode", 16'h0001, 16'(burst_mode_o));
        cmd(CMD_AUTOSEL);
        rd(19'h00003, WORD_TRUE);
        wr(19'h00000, 16'(CMD_RESET));
        chk("mode", 16'h0001, 16'(burst_mode_o));
        addr <= 19'h00100;
        run_bclk <= 1'b1;
        repeat (4) @(posedge burst_clk);
        load_burst_addr_n <= 1'b0;
        @(posedge burst_clk);
        load_burst_addr_n <= 1'b1;
        @(posedge burst_clk);
        burst_advance_n <= 1'b0;
        #1;
        chk("word0", 16'h1234, burst_dq_o);
        n = 0;
        while (burst_end_flag_n !== 1'b0 && n < 40)
        begin
            @(posedge burst_clk);
            #1;
            n++;
        end
        chk("steps", 16'h001f, 16'(n));
        chk("last", WORD_ERASED, burst_dq_o);
        burst_advance_n <= 1'b1;
        set_burst(BURST_DISABLE);
        chk("mode", 16'h0000, 16'(burst_mode_o));
        set_burst(BURST_ENABLE);
        hw_reset_n <= 1'b0;
        repeat (6) @(posedge sys_clk);
        hw_reset_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        chk("mode", 16'h0000, 16'(burst_mode_o));
        cmd(CMD_PROGRAM);
        wr(19'h00400, 16'h5555);
        hw_reset_n <= 1'b0;
        repeat (6) @(posedge sys_clk);
        hw_reset_n <= 1'b1;
        chk("ready", 16'h0001, 16'(ready_busy_out));
        run_bclk <= 1'b0;
        erase_suspend_i <= 1'b1;
        rd(19'h02000, WORD_SUSP_STATUS);
        rd(19'h00100, 16'h1234);
        report_and_stop();
    end
endmodule // testbench

`default_nettype wire
